// >>> pkg/dsd_pkg.sv
/*
  Shared constants and types for the dual synthesizer digital core.
  Assumes a single 50 MHz system clock and a 24-bit serial programming word.
*/
package dsd_pkg;

  // Clock and anti-backlash timing.
  localparam int CLK_NS = 20;
  localparam int ABP_NS = 40;
  localparam int ABP_CYC = (ABP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] ABP_CNT = ABP_CYC[1:0];

  // Serial word and latch select codes.
  localparam int WORD_W = 24;
  localparam logic [2:0] LS_RF_N = 3'h0;
  localparam logic [2:0] LS_RF_R = 3'h1;
  localparam logic [2:0] LS_RF_CTL = 3'h2;
  localparam logic [2:0] LS_MASTER = 3'h3;
  localparam logic [2:0] LS_IF_N = 3'h4;
  localparam logic [2:0] LS_IF_R = 3'h5;
  localparam logic [2:0] LS_IF_CTL = 3'h6;

  // Field positions inside the shifted word.
  localparam int RF_FRAC_LSB = 3;
  localparam int RF_INT_LSB = 15;
  localparam int RF_MOD_LSB = 3;
  localparam int RF_R_LSB = 15;
  localparam int RF_DBL_BIT = 19;
  localparam int CTL_LSB = 3;
  localparam int MON_LSB = 7;
  localparam int IF_A_LSB = 3;
  localparam int IF_B_LSB = 9;
  localparam int IF_P_LSB = 21;
  localparam int IF_R_LSB = 3;
  localparam int IF_DBL_BIT = 18;

  // Control bit positions within a stored three-bit control group.
  localparam int CB_CNTRST = 0;
  localparam int CB_TRI = 1;
  localparam int CB_PWRDN = 2;

  // Programming limits and reset values.
  localparam logic [7:0] RF_INT_MIN = 8'h1F;
  localparam logic [11:0] RF_MOD_MIN = 12'h002;
  localparam logic [11:0] IF_B_MIN = 12'h003;
  localparam logic [7:0] RST_INT = 8'h1F;
  localparam logic [11:0] RST_MOD = 12'h002;
  localparam logic [3:0] RST_RF_R = 4'h1;
  localparam logic [11:0] RST_IF_B = 12'h003;
  localparam logic [14:0] RST_IF_R = 15'h0001;
  localparam logic [7:0] RST_NEED = 8'h10;
  localparam logic [7:0] RST_WIN = 8'h03;

  // Register bus byte offsets.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_LOCKCFG = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_LASTWORD = 8'h10;

  // Event bits of the status and mask registers.
  localparam int EV_W = 5;
  localparam int EV_LOADED = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_RF_LOCK = 2;
  localparam int EV_IF_LOCK = 3;
  localparam int EV_LOST = 4;

  // Monitor select codes.
  localparam logic [3:0] MON_TRI = 4'h0;
  localparam logic [3:0] MON_DLOCK = 4'h1;
  localparam logic [3:0] MON_RF_REF = 4'h2;
  localparam logic [3:0] MON_RF_FB = 4'h3;
  localparam logic [3:0] MON_IF_REF = 4'h4;
  localparam logic [3:0] MON_IF_FB = 4'h5;
  localparam logic [3:0] MON_RF_ALOCK = 4'h6;
  localparam logic [3:0] MON_IF_ALOCK = 4'h7;
  localparam logic [3:0] MON_HIGH = 4'h8;

  typedef enum logic [3:0] {
    PFD_IDLE = 4'h1,
    PFD_UP = 4'h2,
    PFD_DN = 4'h4,
    PFD_RST = 4'h8
  } dsd_pfd_state_t;

  typedef struct packed {
    dsd_pfd_state_t state;
    logic [7:0] err;
    logic [1:0] ab;
    logic [7:0] good;
    logic lock;
  } dsd_pfd_t;

endpackage

// >>> pkg/dsd_div_if.sv
/*
  Link between the core and one programmable divider.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface dsd_div_if #(parameter int W = 8);
  logic tick;
  logic clear;
  logic [W-1:0] ratio;
  logic pulse;
  modport user (output tick, output clear, output ratio, input pulse);
  modport div (input tick, input clear, input ratio, output pulse);
endinterface

// >>> hw/dsd_divider.sv
/*
  Programmable divider: one output pulse for every ratio input ticks.
  Assumes ticks are single-cycle strobes on the system clock.
*/
`timescale 1ns/1ps
module dsd_divider
  import dsd_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Divider link
  dsd_div_if.div dv
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic pulse;
  } dsd_divst_t;

  dsd_divst_t st_r;
  dsd_divst_t st_nxt;
  logic [W-1:0] ratioEff;

  if (W < 2 || W > 24) begin : g_chk
    $error("Divider width out of range.");
  end

  // A zero ratio behaves as one, so the output never stops.
  assign ratioEff = (dv.ratio == '0) ? W'(1) : dv.ratio;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (dv.clear) begin
      st_nxt.cnt = '0;
    end else if (dv.tick) begin
      if (st_r.cnt >= ratioEff - W'(1)) begin // R5
        st_nxt.cnt = '0;
        st_nxt.pulse = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dv.pulse = st_r.pulse;

endmodule

// >>> hw/dsd_core.sv
/*
  Dual synthesizer digital core: serial load path, seven target latches,
  RF fractional and IF pulse swallow feedback dividers, reference dividers,
  phase detectors, lock detect, monitor pin and an AHB-Lite status port.
  Assumes all pin inputs are asynchronous and are far slower than clk_sys.
*/
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Summary of operation
// R1: RF integer value held within 31..255.
// R2: RF division is integer plus fraction over modulus.
// R3: RF modulus is 12 bits, at least 2.
// R4: RF reference divided 1..15, optional doubling.
// R5: IF reference divided 1..32767.
// R6: IF feedback divides by prescaler times main plus swallow.
// R7: IF main count is 12 bits, at least 3.
// R8: IF swallow count takes 0..63.
// R9: Phase detectors compare with anti-backlash pulse.
// R10: Monitor source chosen by master select field.
// R11: Monitor offers digital and analog lock, digital high.
// R12: Analog lock rests high with low pulses.
// R13: One data bit captured per serial clock rise.
// R14: Host shifts most significant bit first.
// R15: Load strobe rise copies word to a latch.
// R16: Latch chosen by three lowest word bits.
// R17: Codes 0..3 load RF and master latches.
// R18: Codes 4..6 load IF latches.
// R19: Code 7 leaves every latch unchanged.
module dsd_core
  import dsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial programming pins
  input wire logic sclk,
  input wire logic sdata,
  input wire logic loadStrobe,
  // Reference and feedback inputs
  input wire logic referenceInput,
  input wire logic rfFeedbackIn,
  input wire logic ifFeedbackIn,
  // Charge pump drives
  output logic rfPumpUp,
  output logic rfPumpDn,
  output logic ifPumpUp,
  output logic ifPumpDn,
  // Monitor pin
  output logic monitorOutputPinO,
  output logic monitorOutputPinOe,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Interrupt
  output logic irq
);

  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_REF = 3;
  localparam int PIN_RFFB = 4;
  localparam int PIN_IFFB = 5;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] lastWord;
    logic [2:0] lastCode;
    logic [7:0] rfInt;
    logic [11:0] rfFrac;
    logic [11:0] rfMod;
    logic [3:0] rfR;
    logic rfDbl;
    logic [2:0] rfCtl;
    logic [2:0] masterCtl;
    logic [3:0] monitorSelectField;
    logic [11:0] ifB;
    logic [5:0] ifA;
    logic [1:0] ifPsel;
    logic [14:0] ifR;
    logic ifDbl;
    logic [2:0] ifCtl;
    logic [11:0] acc;
    logic [8:0] rfRatio;
    dsd_pfd_t pdRf;
    dsd_pfd_t pdIf;
    logic pumpRfUp;
    logic pumpRfDn;
    logic pumpIfUp;
    logic pumpIfDn;
    logic monO;
    logic monOe;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [7:0] lockNeed;
    logic [7:0] lockWin;
    logic dpWrite;
    logic [7:0] dpAddr;
    logic [31:0] rdata;
    logic readyOut;
    logic resp;
    logic irq;
  } dsd_core_st_t;

  dsd_core_st_t st_r;
  dsd_core_st_t st_nxt;
  logic [5:0] rise;
  logic [5:0] anyEdge;
  logic [2:0] latchSelectBits;
  logic [11:0] fracEff;
  logic [12:0] fracSum;
  logic fracCarry;
  logic rfHold;
  logic ifHold;
  logic addrPhase;
  logic [EV_W-1:0] setEv;
  logic [EV_W-1:0] clrEv;

  dsd_div_if #(.W(4)) rfRefDiv ();
  dsd_div_if #(.W(9)) rfFbDiv ();
  dsd_div_if #(.W(15)) ifRefDiv ();
  dsd_div_if #(.W(18)) ifFbDiv ();

  // One step of a phase detector with its lock qualifier.
  function automatic dsd_pfd_t pfd_next(dsd_pfd_t p, logic refP, logic fbP,
                                        logic [7:0] need, logic [7:0] win);
    dsd_pfd_t n;
    logic hit;
    n = p;
    hit = 1'b0;
    case (p.state)
      PFD_IDLE: begin
        n.err = 8'h00;
        if (refP && fbP) begin
          hit = 1'b1;
        end else if (refP) begin
          n.state = PFD_UP;
        end else if (fbP) begin
          n.state = PFD_DN;
        end
      end
      PFD_UP, PFD_DN: begin
        if (p.err != 8'hFF) begin
          n.err = p.err + 8'h01;
        end
        hit = (p.state == PFD_UP) ? fbP : refP;
      end
      PFD_RST: begin
        if (p.ab == 2'h1) begin
          n.state = PFD_IDLE;
        end else begin
          n.ab = p.ab - 2'h1;
        end
      end
      default: n.state = PFD_IDLE;
    endcase
    // Both pumps stay on briefly so tiny phase errors still produce charge.
    if (hit) begin
      n.state = PFD_RST; // R9
      n.ab = ABP_CNT;
      if (p.err <= win) begin
        n.good = (p.good >= need) ? p.good : p.good + 8'h01;
      end else begin
        n.good = 8'h00;
      end
      n.lock = (n.good >= need);
    end
    return n;
  endfunction

  assign rise = st_r.s2 & ~st_r.s3;
  assign anyEdge = st_r.s2 ^ st_r.s3;
  assign latchSelectBits = st_r.shift[2:0];
  assign rfHold = st_r.rfCtl[CB_CNTRST] | st_r.rfCtl[CB_PWRDN] |
                  st_r.masterCtl[CB_CNTRST] | st_r.masterCtl[CB_PWRDN];
  assign ifHold = st_r.ifCtl[CB_CNTRST] | st_r.ifCtl[CB_PWRDN] |
                  st_r.masterCtl[CB_CNTRST] | st_r.masterCtl[CB_PWRDN];
  assign addrPhase = hsel & htrans[1] & hready;

  // A fraction above the modulus is clamped, which keeps the accumulator below it.
  assign fracEff = (st_r.rfFrac > st_r.rfMod) ? st_r.rfMod : st_r.rfFrac;
  assign fracSum = {1'b0, st_r.acc} + {1'b0, fracEff};
  assign fracCarry = (fracSum >= {1'b0, st_r.rfMod});

  assign rfRefDiv.tick = st_r.rfDbl ? anyEdge[PIN_REF] : rise[PIN_REF]; // R4
  assign rfRefDiv.clear = rfHold;
  assign rfRefDiv.ratio = st_r.rfR;
  assign rfFbDiv.tick = rise[PIN_RFFB];
  assign rfFbDiv.clear = rfHold;
  assign rfFbDiv.ratio = st_r.rfRatio;
  assign ifRefDiv.tick = st_r.ifDbl ? anyEdge[PIN_REF] : rise[PIN_REF]; // R5
  assign ifRefDiv.clear = ifHold;
  assign ifRefDiv.ratio = st_r.ifR;
  assign ifFbDiv.tick = rise[PIN_IFFB];
  assign ifFbDiv.clear = ifHold;
  assign ifFbDiv.ratio = ({6'h00, st_r.ifB} << ({1'b0, st_r.ifPsel} + 3'h3)) +
                         {12'h000, st_r.ifA}; // R6 R8

  dsd_divider #(.W(4)) uRfRef (.clk_sys(clk_sys), .reset_n(reset_n), .dv(rfRefDiv));
  dsd_divider #(.W(9)) uRfFb (.clk_sys(clk_sys), .reset_n(reset_n), .dv(rfFbDiv));
  dsd_divider #(.W(15)) uIfRef (.clk_sys(clk_sys), .reset_n(reset_n), .dv(ifRefDiv));
  dsd_divider #(.W(18)) uIfFb (.clk_sys(clk_sys), .reset_n(reset_n), .dv(ifFbDiv));

  always_comb begin
    st_nxt = st_r;
    setEv = '0;
    clrEv = '0;
    st_nxt.s1 = {ifFeedbackIn, rfFeedbackIn, referenceInput, loadStrobe, sdata, sclk};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    if (rise[PIN_SCLK]) begin
      st_nxt.shift = {st_r.shift[WORD_W-2:0], st_r.s2[PIN_SDATA]}; // R13 R14
    end
    if (rise[PIN_LOAD]) begin
      st_nxt.lastWord = st_r.shift; // R15
      st_nxt.lastCode = latchSelectBits;
      setEv[EV_LOADED] = 1'b1;
      case (latchSelectBits) // R16
        LS_RF_N: begin
          if (st_r.shift[RF_INT_LSB +: 8] >= RF_INT_MIN) begin // R1
            st_nxt.rfInt = st_r.shift[RF_INT_LSB +: 8]; // R17
            st_nxt.rfFrac = st_r.shift[RF_FRAC_LSB +: 12];
          end else begin
            setEv[EV_REJECT] = 1'b1;
          end
        end
        LS_RF_R: begin
          if (st_r.shift[RF_MOD_LSB +: 12] >= RF_MOD_MIN) begin // R3
            st_nxt.rfMod = st_r.shift[RF_MOD_LSB +: 12]; // R17
            st_nxt.rfR = st_r.shift[RF_R_LSB +: 4];
            st_nxt.rfDbl = st_r.shift[RF_DBL_BIT];
          end else begin
            setEv[EV_REJECT] = 1'b1;
          end
        end
        LS_RF_CTL: st_nxt.rfCtl = st_r.shift[CTL_LSB +: 3]; // R17
        LS_MASTER: begin
          st_nxt.masterCtl = st_r.shift[CTL_LSB +: 3]; // R17
          st_nxt.monitorSelectField = st_r.shift[MON_LSB +: 4]; // R10
        end
        LS_IF_N: begin
          if (st_r.shift[IF_B_LSB +: 12] >= IF_B_MIN) begin // R7
            st_nxt.ifB = st_r.shift[IF_B_LSB +: 12]; // R18
            st_nxt.ifA = st_r.shift[IF_A_LSB +: 6];
            st_nxt.ifPsel = st_r.shift[IF_P_LSB +: 2];
          end else begin
            setEv[EV_REJECT] = 1'b1;
          end
        end
        LS_IF_R: begin
          st_nxt.ifR = st_r.shift[IF_R_LSB +: 15]; // R18
          st_nxt.ifDbl = st_r.shift[IF_DBL_BIT];
        end
        LS_IF_CTL: st_nxt.ifCtl = st_r.shift[CTL_LSB +: 3]; // R18
        default: ; // R19
      endcase
    end

    // Each feedback period picks INT or INT+1 from the fraction accumulator.
    if (rfHold) begin
      st_nxt.acc = 12'h000;
      st_nxt.rfRatio = {1'b0, st_r.rfInt};
    end else if (rfFbDiv.pulse) begin
      st_nxt.acc = fracCarry ? 12'(fracSum - {1'b0, st_r.rfMod}) : fracSum[11:0]; // R2
      st_nxt.rfRatio = {1'b0, st_r.rfInt} + {8'h00, fracCarry};
    end

    if (rfHold) begin
      st_nxt.pdRf = '{state: PFD_IDLE, default: '0};
    end else begin
      st_nxt.pdRf = pfd_next(st_r.pdRf, rfRefDiv.pulse, rfFbDiv.pulse,
                             st_r.lockNeed, st_r.lockWin); // R9
    end
    if (ifHold) begin
      st_nxt.pdIf = '{state: PFD_IDLE, default: '0};
    end else begin
      st_nxt.pdIf = pfd_next(st_r.pdIf, ifRefDiv.pulse, ifFbDiv.pulse,
                             st_r.lockNeed, st_r.lockWin); // R9
    end
    setEv[EV_RF_LOCK] = st_nxt.pdRf.lock & ~st_r.pdRf.lock;
    setEv[EV_IF_LOCK] = st_nxt.pdIf.lock & ~st_r.pdIf.lock;
    setEv[EV_LOST] = (st_r.pdRf.lock & ~st_nxt.pdRf.lock) |
                     (st_r.pdIf.lock & ~st_nxt.pdIf.lock);

    st_nxt.pumpRfUp = (st_nxt.pdRf.state inside {PFD_UP, PFD_RST}) &
                      ~st_r.rfCtl[CB_TRI] & ~st_r.masterCtl[CB_TRI];
    st_nxt.pumpRfDn = (st_nxt.pdRf.state inside {PFD_DN, PFD_RST}) &
                      ~st_r.rfCtl[CB_TRI] & ~st_r.masterCtl[CB_TRI];
    st_nxt.pumpIfUp = (st_nxt.pdIf.state inside {PFD_UP, PFD_RST}) &
                      ~st_r.ifCtl[CB_TRI] & ~st_r.masterCtl[CB_TRI];
    st_nxt.pumpIfDn = (st_nxt.pdIf.state inside {PFD_DN, PFD_RST}) &
                      ~st_r.ifCtl[CB_TRI] & ~st_r.masterCtl[CB_TRI];

    // Analog lock pulls low while the selected detector is out of idle, anti-backlash reset included.
    st_nxt.monO = 1'b0;
    st_nxt.monOe = 1'b1;
    case (st_r.monitorSelectField) // R10
      MON_TRI: st_nxt.monOe = 1'b0;
      MON_DLOCK: st_nxt.monO = st_r.pdRf.lock & st_r.pdIf.lock; // R11
      MON_RF_REF: st_nxt.monO = rfRefDiv.pulse;
      MON_RF_FB: st_nxt.monO = rfFbDiv.pulse;
      MON_IF_REF: st_nxt.monO = ifRefDiv.pulse;
      MON_IF_FB: st_nxt.monO = ifFbDiv.pulse;
      MON_RF_ALOCK: st_nxt.monOe = (st_r.pdRf.state != PFD_IDLE); // R12
      MON_IF_ALOCK: st_nxt.monOe = (st_r.pdIf.state != PFD_IDLE); // R12
      MON_HIGH: st_nxt.monO = 1'b1;
      default: st_nxt.monO = 1'b0;
    endcase

    st_nxt.readyOut = 1'b1;
    st_nxt.resp = 1'b0;
    if (st_r.dpWrite) begin
      case (st_r.dpAddr)
        ADDR_STATUS: clrEv = hwdata[EV_W-1:0];
        ADDR_MASK: st_nxt.mask = hwdata[EV_W-1:0];
        ADDR_LOCKCFG: begin
          st_nxt.lockNeed = hwdata[7:0];
          st_nxt.lockWin = hwdata[15:8];
        end
        default: ;
      endcase
    end
    st_nxt.dpWrite = 1'b0;
    if (addrPhase) begin
      st_nxt.dpWrite = hwrite & (haddr[31:8] == 24'h000000);
      st_nxt.dpAddr = haddr[7:0];
      st_nxt.rdata = 32'h00000000;
      if (!hwrite && haddr[31:8] == 24'h000000) begin
        case (haddr[7:0])
          ADDR_STATUS: st_nxt.rdata = {27'h0000000, st_r.status};
          ADDR_MASK: st_nxt.rdata = {27'h0000000, st_r.mask};
          ADDR_LOCKCFG: st_nxt.rdata = {16'h0000, st_r.lockWin, st_r.lockNeed};
          ADDR_STATE: st_nxt.rdata = {23'h000000, st_r.monitorSelectField,
                                      st_r.lastCode, st_r.pdIf.lock, st_r.pdRf.lock};
          ADDR_LASTWORD: st_nxt.rdata = {8'h00, st_r.lastWord};
          default: st_nxt.rdata = 32'h00000000;
        endcase
      end
    end

    // A new event in the clearing cycle survives the clear.
    st_nxt.status = (st_r.status & ~clrEv) | setEv;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.rfInt <= RST_INT;
      st_r.rfMod <= RST_MOD;
      st_r.rfR <= RST_RF_R;
      st_r.rfRatio <= {1'b0, RST_INT};
      st_r.ifB <= RST_IF_B;
      st_r.ifR <= RST_IF_R;
      st_r.pdRf.state <= PFD_IDLE;
      st_r.pdIf.state <= PFD_IDLE;
      st_r.lockNeed <= RST_NEED;
      st_r.lockWin <= RST_WIN;
      st_r.readyOut <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rfPumpUp = st_r.pumpRfUp;
  assign rfPumpDn = st_r.pumpRfDn;
  assign ifPumpUp = st_r.pumpIfUp;
  assign ifPumpDn = st_r.pumpIfDn;
  assign monitorOutputPinO = st_r.monO;
  assign monitorOutputPinOe = st_r.monOe;
  assign hreadyout = st_r.readyOut;
  assign hrdata = st_r.rdata;
  assign hresp = st_r.resp;
  assign irq = st_r.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_rf_int_range: assert property (st_r.rfInt >= RF_INT_MIN) // R1
    else $error("RF integer value below minimum.");
  a_rf_frac_ratio: assert property (rfFbDiv.pulse && !rfHold |=> // R2
      st_r.rfRatio - {1'b0, $past(st_r.rfInt)} inside {9'h000, 9'h001})
    else $error("RF feedback ratio is not INT or INT+1.");
  a_rf_mod_range: assert property (st_r.rfMod >= RF_MOD_MIN) // R3
    else $error("RF modulus below minimum.");
  a_if_b_range: assert property (st_r.ifB >= IF_B_MIN) // R7
    else $error("IF main count below minimum.");
  a_if_n_ratio: assert property (32'(ifFbDiv.ratio) == // R6
      (32'(st_r.ifB) * (32'h8 << st_r.ifPsel)) + 32'(st_r.ifA))
    else $error("IF feedback ratio differs from P*B+A.");
  a_pfd_backlash: assert property ($rose(st_r.pdRf.state == PFD_RST) |-> // R9
      (rfPumpUp == !(st_r.rfCtl[CB_TRI] | st_r.masterCtl[CB_TRI]) &&
      st_r.pdRf.state == PFD_RST) [*2]
      ##1 st_r.pdRf.state == PFD_IDLE || rfHold)
    else $error("RF anti-backlash pulse has wrong length.");
  a_monitor_select: assert property (rise[PIN_LOAD] && latchSelectBits == LS_MASTER |=> // R10
      st_r.monitorSelectField == $past(st_r.shift[MON_LSB +: 4]))
    else $error("Monitor select not taken from master word.");
  a_monitor_dlock: assert property (st_r.monitorSelectField == MON_DLOCK && // R11
      $stable(st_r.monitorSelectField) |=> monitorOutputPinOe &&
      monitorOutputPinO == $past(st_r.pdRf.lock && st_r.pdIf.lock))
    else $error("Digital lock not driven high on monitor.");
  a_analog_release: assert property (st_r.monitorSelectField == MON_RF_ALOCK && // R12
      st_r.pdRf.state == PFD_IDLE |=> !monitorOutputPinO && !monitorOutputPinOe)
    else $error("Analog lock pin not released while idle.");
  a_shift_capture: assert property (rise[PIN_SCLK] |=> // R13
      st_r.shift == {$past(st_r.shift[WORD_W-2:0]), $past(st_r.s2[PIN_SDATA])})
    else $error("Serial bit not captured on clock rise.");
  a_latch_rf_n: assert property (rise[PIN_LOAD] && latchSelectBits == LS_RF_N && // R17
      st_r.shift[RF_INT_LSB +: 8] >= RF_INT_MIN |=>
      st_r.rfFrac == $past(st_r.shift[RF_FRAC_LSB +: 12]))
    else $error("RF N latch not loaded.");
  a_latch_if_r: assert property (rise[PIN_LOAD] && latchSelectBits == LS_IF_R |=> // R18
      st_r.ifR == $past(st_r.shift[IF_R_LSB +: 15]))
    else $error("IF R latch not loaded.");
  a_null_code: assert property (rise[PIN_LOAD] && latchSelectBits == 3'h7 |=> // R19
      $stable(st_r.rfInt) && $stable(st_r.rfMod) && $stable(st_r.ifB) &&
      $stable(st_r.ifR) && $stable(st_r.masterCtl) && $stable(st_r.ifCtl))
    else $error("Unassigned code changed a latch.");

endmodule

// >>> verif/dsd_host_model.sv
/*
  Host controller model that drives the three-wire programming port.
  Assumes the bench calls send from one process, on the system clock.
*/
`timescale 1ns/1ps
module dsd_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial programming pins
  output logic sclk,
  output logic sdata,
  output logic loadStrobe
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    loadStrobe = 1'b0;
  end
  // Each phase lasts four clocks, one more than needed, to absorb synchroniser jitter.
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_sys);
      sdata <= word[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    loadStrobe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    loadStrobe <= 1'b0;
    sdata <= ~word[0];
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// >>> verif/dual_synth_dividers_and_serial_load_test.sv
/*
  Self-checking bench for the synthesizer core: serial loads, monitor pin,
  reference dividers and the status and interrupt registers.
  Assumes the core answers the bus with zero wait states.
*/
`timescale 1ns/1ps
module dual_synth_dividers_and_serial_load_test;
  import dsd_pkg::*;
  logic clk_sys, reset_n, referenceInput, hsel, hwrite, hreadyout, hresp, irq;
  logic sclk, sdata, loadStrobe, rfPumpUp, rfPumpDn, ifPumpUp, ifPumpDn, monO, monOe;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  int miscompares = 0, checked = 0, cycles = 0, refRises = 0, n0;
  // The monitor pin is open drain when released, so the pull-up shows.
  wire logic monWire = monOe ? monO : 1'b1;
  dsd_host_model i_dsd_host_model (.clk_sys(clk_sys), .sclk(sclk), .sdata(sdata),
    .loadStrobe(loadStrobe));
  // Feedback inputs follow the reference; the ratios differ so much that lock never comes.
  dsd_core i_dsd_core (.clk_sys(clk_sys), .reset_n(reset_n), .sclk(sclk), .sdata(sdata),
    .loadStrobe(loadStrobe), .referenceInput(referenceInput), .rfFeedbackIn(referenceInput),
    .ifFeedbackIn(referenceInput), .rfPumpUp(rfPumpUp), .rfPumpDn(rfPumpDn), .ifPumpUp(ifPumpUp),
    .ifPumpDn(ifPumpDn), .monitorOutputPinO(monO), .monitorOutputPinOe(monOe),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    referenceInput = 1'b0;
    forever begin
      repeat (4) @(posedge clk_sys);
      if (referenceInput == 1'b0) refRises <= refRises + 1;
      referenceInput <= ~referenceInput;
    end
  end
  task automatic stop_test;
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
    @(negedge clk_sys);
  endtask
  task automatic waitRise;
    logic p;
    p = monWire;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (monWire === 1'b1 && p === 1'b0) return;
      p = monWire;
    end
    miscompares++;
  endtask
  task automatic test_reset;
    logic [7:0] a [5] = '{ADDR_STATUS, ADDR_MASK, ADDR_LOCKCFG, ADDR_STATE, 8'h40};
    logic [31:0] e [5] = '{32'h0, 32'h0, 32'h00000310, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 32'h0);
      check("reset reg", q, e[i]);
    end
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
  endtask
  task automatic test_monitor;
    logic [3:0] s [4] = '{MON_TRI, MON_DLOCK, MON_HIGH, 4'h9};
    logic [1:0] e [4] = '{2'b01, 2'b10, 2'b11, 2'b10};
    for (int i = 0; i < 4; i++) begin
      i_dsd_host_model.send({13'h0, s[i], 4'h0, LS_MASTER});
      check("monitor pin", {30'h0, monOe, monWire}, {30'h0, e[i]});
      bus(1'b0, ADDR_STATE, 32'h0);
      check("state sel/code", {25'h0, q[8:2]}, {25'h0, s[i], LS_MASTER});
    end
    bus(1'b0, ADDR_LASTWORD, 32'h0);
    check("last word", q, {8'h0, 13'h0, 4'h9, 4'h0, LS_MASTER});
    bus(1'b1, ADDR_STATUS, 32'h0000001F);
    i_dsd_host_model.send({13'h0, MON_HIGH, 4'h0, 3'h7});
    bus(1'b0, ADDR_STATE, 32'h0);
    check("code 7 select", {28'h0, q[8:5]}, 32'h9);
    check("code 7 pin", {31'h0, monWire}, 32'h0);
  endtask
  task automatic test_reject;
    logic [23:0] w [3] = '{24'h0F0000 | {21'h0, LS_RF_N}, 24'h000008 | {21'h0, LS_RF_R},
      24'h000400 | {21'h0, LS_IF_N}};
    bus(1'b1, ADDR_MASK, 32'h00000002);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ADDR_STATUS, 32'h0000001F);
      check("irq cleared", {31'h0, irq}, 32'h0);
      i_dsd_host_model.send(w[i]);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("reject events", {30'h0, q[1:0]}, 32'h3);
      check("irq raised", {31'h0, irq}, 32'h1);
    end
    bus(1'b1, ADDR_STATUS, 32'h0000001F);
    i_dsd_host_model.send(24'h100008);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("accepted load", {30'h0, q[1:0]}, 32'h1);
    check("irq quiet", {31'h0, irq}, 32'h0);
    bus(1'b0, ADDR_LASTWORD, 32'h0);
    check("rf n word", q, 32'h00100008);
    bus(1'b1, ADDR_MASK, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
  endtask
  task automatic test_dividers;
    logic [23:0] w [3] = '{24'h018010 | {21'h0, LS_RF_R}, 24'h098010 | {21'h0, LS_RF_R},
      24'h000028 | {21'h0, LS_IF_R}};
    logic [3:0] s [3] = '{MON_RF_REF, MON_RF_REF, MON_IF_REF};
    int e [3] = '{6, 3, 10};
    for (int i = 0; i < 3; i++) begin
      i_dsd_host_model.send(w[i]);
      i_dsd_host_model.send({13'h0, s[i], 4'h0, LS_MASTER});
      waitRise();
      waitRise();
      n0 = refRises;
      waitRise();
      waitRise();
      check("ref rises per two pulses", refRises - n0, e[i]);
    end
    bus(1'b0, ADDR_LASTWORD, 32'h0);
    check("last word", q, {8'h0, 13'h0, MON_IF_REF, 4'h0, LS_MASTER});
  endtask
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_reset();
    test_monitor();
    test_reject();
    test_dividers();
    stop_test();
  end
endmodule
